// ### testbench/acquisition_mode_status_controller_bench.sv
// self-checking bench for the acquisition mode status controller
`timescale 1ns/10ps
module acquisition_mode_status_controller_bench;
   import amsc_pkg::*;
   localparam int CY = 4; // shortened ms
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awaddr, araddr, wstrb;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic st_done, st_fatal, dhcp, cmd_valid, cmd_accept, cmd_drop, led_t, led_b;
   logic [7:0] cmd_src;
   logic [15:0] dio_in, dio_out, dio_oe;
   int n_errors = 0;
   int checks_done = 0;
   int tick = 0;
   int m_mode, m_lock, m_id;
   amsc_top #(.ID_W(8), .CYC_PER_MS(CY), .WAIT_TMO_MS(50), .WORK_IDLE_MS(10), .DARK_MS(3), .ERR_PER_MS(4),
      .IDLE_PER_MS(20), .BLINK_MS(2), .PULSE_MS(2)) DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .selftest_done(st_done), .selftest_fatal(st_fatal), .addr_dhcp(dhcp),
      .cmd_valid(cmd_valid), .cmd_src(cmd_src), .cmd_accept(cmd_accept), .cmd_drop(cmd_drop),
      .led_traffic(led_t), .led_busy(led_b), .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe));
   amsc_host #(.ID_W(8)) host (.aclk(aclk), .cmd_valid(cmd_valid), .cmd_src(cmd_src),
      .cmd_accept(cmd_accept), .cmd_drop(cmd_drop));
   always #2 aclk = ~aclk;
   // generous ceiling, the run needs under two thousand cycles
   always @(posedge aclk) begin
      tick++;
      if (tick == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   task automatic give_verdict;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= aw;
      wdata <= d;
      wstrb <= s;
      wvalid <= w;
      bready <= 1'b1;
      // each valid mirrors its own pending flag, released on its own handshake
      while (aw || w) begin
         @(posedge aclk);
         if (awready === 1'b1) aw = 1'b0;
         if (wready === 1'b1) w = 1'b0;
         awvalid <= aw;
         wvalid <= w;
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(bresp, (a[1:0] != 2'h0) ? 2 : 0);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      rready <= 1'b0;
      chk(rresp, (a[1:0] != 2'h0) ? 2 : 0);
   endtask : rd
   // id field only meaningful while locked
   task automatic stat;
      logic [31:0] d, e;
      rd(AMSC_REG_STAT, d);
      e = m_mode | (m_lock << 8) | (m_lock != 0 ? m_id << 16 : 0);
      chk(m_lock != 0 ? d : d & 32'hff00ffff, e);
   endtask : stat
   task automatic cmd(input logic [7:0] id);
      logic [1:0] a;
      logic ok;
      ok = (m_mode == AMSC_IDLE) || ((m_mode == AMSC_WORK || m_mode == AMSC_WAIT) && id == m_id);
      host.send(id, a);
      chk(a, ok ? 2 : 1);
      if (ok) begin
         m_mode = AMSC_WORK;
         m_lock = 1;
         m_id = id;
      end
   endtask : cmd
   task automatic rises(input bit busy, input int n, input int exp);
      int c;
      logic p, v;
      c = 0;
      p = busy ? led_b : led_t;
      repeat (n) begin
         @(posedge aclk);
         #1 v = busy ? led_b : led_t;
         if (v && !p) c++;
         p = v;
      end
      chk(c, exp);
   endtask : rises
   initial begin
      logic [31:0] d, r;
      logic [7:0] a;
      logic [3:0] s;
      logic [15:0] o;
      int i;
      {awaddr, araddr, wstrb, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
      {st_done, st_fatal, dhcp, dio_in} = '0;
      void'($urandom(94971));
      m_mode = AMSC_SELF;
      m_lock = 0;
      m_id = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      cyc(3);
      chk({led_t, led_b}, 2'b11);
      stat();
      cmd(8'h5a);
      for (i = 0; i < 4; i++) begin
         wr(AMSC_REG_CTRL, i, 4'h1 | 4'($urandom));
         cyc(2);
         chk(dio_oe, {{8{i[1]}}, {8{i[0]}}});
      end
      // without the low byte strobe the direction must stay as it is
      wr(AMSC_REG_CTRL, 32'h0, 4'he);
      cyc(2);
      chk(dio_oe, 16'hffff);
      d = $urandom;
      s = $urandom;
      wr(AMSC_REG_DOUT, d, s);
      cyc(1);
      o = {s[1] ? d[15:8] : AMSC_DOUT_RST[15:8], s[0] ? d[7:0] : AMSC_DOUT_RST[7:0]};
      chk(dio_out, o);
      // unaligned address is unmapped: error answer, no effect, zero data
      wr(4'h6, ~d, 4'hf);
      rd(4'h3, r);
      chk(r, 32'h0);
      chk(dio_out, o);
      @(posedge aclk);
      dio_in <= d[31:16];
      rd(AMSC_REG_DIN, r);
      chk(r, d[31:16]);
      @(posedge aclk);
      st_done <= 1'b1;
      cyc(4);
      m_mode = AMSC_DARK;
      chk({led_t, led_b}, 2'b00);
      stat();
      cyc(6 * CY);
      m_mode = AMSC_IDLE;
      stat();
      chk(led_b, 1'b0);
      for (i = 0; i < 2; i++) begin
         @(posedge aclk);
         dhcp <= i[0];
         cyc(20 * CY);
         rises(0, 20 * CY, 2 - i);
      end
      a = $urandom;
      cmd(a);
      stat();
      cmd(~a);
      cyc(5 * CY);
      // count from before the command so the pulse's own rise is seen
      fork
         cmd(a);
         rises(0, 4 * CY, 1);
      join
      chk(led_b, 1'b1);
      for (i = 0; i < 4; i++) begin
         cyc(7 * CY);
         cmd(a);
      end
      stat();
      cyc(13 * CY);
      m_mode = AMSC_WAIT;
      stat();
      cmd(~a);
      cmd(a);
      stat();
      cyc(57 * CY);
      m_mode = AMSC_WAIT;
      stat();
      cyc(6 * CY);
      m_mode = AMSC_IDLE;
      m_lock = 0;
      stat();
      @(posedge aclk);
      aresetn <= 1'b0;
      st_done <= 1'($urandom);
      st_fatal <= 1'b1;
      cyc(2);
      @(posedge aclk);
      aresetn <= 1'b1;
      cyc(8);
      m_mode = AMSC_ERR;
      chk(dio_oe, 16'h0000);
      chk(dio_out, AMSC_DOUT_RST);
      stat();
      chk(led_t, 1'b1);
      rises(1, 16 * CY, 4);
      cmd(a);
      give_verdict();
   end
endmodule : acquisition_mode_status_controller_bench

// ### testbench/amsc_host.sv
// host workstation model issuing single-cycle commands
`timescale 1ns/10ps
module amsc_host
   import amsc_pkg::*;
#(
   parameter int ID_W = 8
) (
   input wire logic aclk,
   output logic cmd_valid,
   output logic [ID_W-1:0] cmd_src,
   input wire logic cmd_accept,
   input wire logic cmd_drop
);
   initial begin
      cmd_valid = 1'b0;
      cmd_src = '0;
   end
   // answer is looked for over two edges, the one-cycle pulse lands in one of them
   task automatic send(input logic [ID_W-1:0] id, output logic [1:0] ans);
      logic [1:0] a;
      @(posedge aclk);
      cmd_valid <= 1'b1;
      cmd_src <= id;
      @(posedge aclk);
      cmd_valid <= 1'b0;
      cmd_src <= ~id; // released id must not linger
      #1 a = {cmd_accept, cmd_drop};
      @(posedge aclk);
      #1 ans = a | {cmd_accept, cmd_drop};
   endtask : send
endmodule : amsc_host

// ### verilog/amsc_pkg.sv
// package of constants and types for the acquisition mode status controller
package amsc_pkg;
   // one-hot operating modes
   typedef enum logic [5:0] {
      AMSC_SELF = 6'h01,
      AMSC_DARK = 6'h02,
      AMSC_IDLE = 6'h04,
      AMSC_WORK = 6'h08,
      AMSC_WAIT = 6'h10,
      AMSC_ERR = 6'h20
   } amsc_mode_t;
   // register byte addresses
   localparam logic [3:0] AMSC_REG_CTRL = 4'h0;
   localparam logic [3:0] AMSC_REG_DOUT = 4'h4;
   localparam logic [3:0] AMSC_REG_DIN = 4'h8;
   localparam logic [3:0] AMSC_REG_STAT = 4'hc;
   // field positions
   localparam int AMSC_CTRL_DIR_LO = 0;
   localparam int AMSC_CTRL_DIR_HI = 1;
   localparam int AMSC_STAT_LOCK = 8;
   localparam int AMSC_STAT_ID = 16;
   // reset values
   localparam logic [1:0] AMSC_DIR_RST = 2'h0;
   localparam logic [15:0] AMSC_DOUT_RST = 16'h0000;
   // timing
   localparam int AMSC_CLK_NS = 4;
   localparam int AMSC_MS_NS = 1000000;
   localparam int AMSC_CYC_PER_MS = AMSC_MS_NS / AMSC_CLK_NS;
   localparam int AMSC_WAIT_TMO_S = 300;
   localparam int AMSC_WAIT_TMO_MS = AMSC_WAIT_TMO_S * 1000;
   localparam int AMSC_WORK_IDLE_MS = 1000;
   localparam int AMSC_DARK_MS = 500;
   localparam int AMSC_ERR_HZ = 5;
   localparam int AMSC_ERR_PER_MS = 1000 / AMSC_ERR_HZ;
   localparam int AMSC_IDLE_PER_MS = 1750;
   localparam int AMSC_BLINK_MS = 100;
   localparam int AMSC_PULSE_MS = 20;
endpackage : amsc_pkg

// ### verilog/amsc_top.sv
// acquisition mode status controller with axi4-lite registers
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
module amsc_top
   import amsc_pkg::*;
#(
   parameter int ID_W = 8,
   parameter int CYC_PER_MS = AMSC_CYC_PER_MS,
   parameter int WAIT_TMO_MS = AMSC_WAIT_TMO_MS,
   parameter int WORK_IDLE_MS = AMSC_WORK_IDLE_MS,
   parameter int DARK_MS = AMSC_DARK_MS,
   parameter int ERR_PER_MS = AMSC_ERR_PER_MS,
   parameter int IDLE_PER_MS = AMSC_IDLE_PER_MS,
   parameter int BLINK_MS = AMSC_BLINK_MS,
   parameter int PULSE_MS = AMSC_PULSE_MS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic selftest_done,
   input wire logic selftest_fatal,
   input wire logic addr_dhcp,
   input wire logic cmd_valid,
   input wire logic [ID_W-1:0] cmd_src,
   output logic cmd_accept,
   output logic cmd_drop,
   output logic led_traffic,
   output logic led_busy,
   input wire logic [15:0] dio_in,
   output logic [15:0] dio_out,
   output logic [15:0] dio_oe
);
   localparam int MSW = 20;
   generate
      if (ID_W < 1 || ID_W > 16 || CYC_PER_MS < 2 || CYC_PER_MS > (1 << 18) || WAIT_TMO_MS >= (1 << MSW) ||
          3 * BLINK_MS >= IDLE_PER_MS || ERR_PER_MS < 2 || PULSE_MS < 1 || PULSE_MS > 255 || DARK_MS < 1) begin : g_chk
         $error("amsc_top: unsupported parameter values");
      end
   endgenerate

   // millisecond tick divider
   logic [17:0] div_ff, nxt_div;
   logic tick;
   always_comb begin
      tick = (div_ff == 18'(CYC_PER_MS - 1));
      nxt_div = tick ? 18'h0 : div_ff + 18'h1;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) div_ff <= 18'h0;
      else div_ff <= nxt_div;
   end

   // mode machine
   amsc_mode_t st_ff, nxt_st;
   logic [MSW-1:0] ms_ff, nxt_ms;
   logic lock_ff, nxt_lock;
   logic [ID_W-1:0] id_ff, nxt_id;
   logic acc_ff, nxt_acc, drop_ff, nxt_drop;
   logic from_lock, acc;
   always_comb begin
      nxt_st = st_ff;
      nxt_lock = lock_ff;
      nxt_id = id_ff;
      from_lock = lock_ff && (cmd_src == id_ff);
      acc = 1'b0;
      nxt_ms = tick ? ms_ff + MSW'(1) : ms_ff;
      case (st_ff)
         AMSC_SELF: begin
            if (selftest_fatal) nxt_st = AMSC_ERR;
            else if (selftest_done) nxt_st = AMSC_DARK;
         end
         AMSC_DARK: begin
            if (ms_ff >= MSW'(DARK_MS)) nxt_st = AMSC_IDLE;
         end
         AMSC_IDLE: begin
            if (cmd_valid) begin
               acc = 1'b1;
               nxt_lock = 1'b1;
               nxt_id = cmd_src;
               nxt_st = AMSC_WORK;
            end
            else if (tick && ms_ff >= MSW'(IDLE_PER_MS - 1)) nxt_ms = '0;
         end
         AMSC_WORK: begin
            if (cmd_valid && from_lock) acc = 1'b1;
            else if (ms_ff >= MSW'(WORK_IDLE_MS)) nxt_st = AMSC_WAIT;
         end
         AMSC_WAIT: begin
            if (cmd_valid && from_lock) begin
               acc = 1'b1;
               nxt_st = AMSC_WORK;
            end
            else if (ms_ff >= MSW'(WAIT_TMO_MS)) begin
               nxt_lock = 1'b0;
               nxt_st = AMSC_IDLE;
            end
         end
         AMSC_ERR: begin
            if (tick && ms_ff >= MSW'(ERR_PER_MS - 1)) nxt_ms = '0;
         end
         default: nxt_st = AMSC_SELF;
      endcase
      // counter restarts on every mode change and every accepted command
      if (acc || nxt_st != st_ff) nxt_ms = '0;
      nxt_acc = acc;
      nxt_drop = cmd_valid && !acc;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= AMSC_SELF;
         ms_ff <= '0;
         lock_ff <= 1'b0;
         id_ff <= '0;
         acc_ff <= 1'b0;
         drop_ff <= 1'b0;
      end
      else begin
         st_ff <= nxt_st;
         ms_ff <= nxt_ms;
         lock_ff <= nxt_lock;
         id_ff <= nxt_id;
         acc_ff <= nxt_acc;
         drop_ff <= nxt_drop;
      end
   end

   // status lights, decoded from the current mode one cycle late
   logic [7:0] pul_ff, nxt_pul;
   logic trf_ff, nxt_trf, bsy_ff, nxt_bsy;
   always_comb begin
      nxt_pul = pul_ff;
      if (acc) nxt_pul = 8'(PULSE_MS);
      else if (tick && pul_ff != 8'h0) nxt_pul = pul_ff - 8'h1;
      nxt_trf = 1'b0;
      nxt_bsy = 1'b0;
      case (st_ff)
         AMSC_SELF: begin
            nxt_trf = 1'b1;
            nxt_bsy = 1'b1;
         end
         AMSC_DARK: begin
            nxt_trf = 1'b0;
         end
         AMSC_IDLE: begin
            // live address origin picks the pattern
            nxt_trf = (ms_ff < MSW'(BLINK_MS)) ||
                      (!addr_dhcp && ms_ff >= MSW'(2 * BLINK_MS) && ms_ff < MSW'(3 * BLINK_MS));
         end
         AMSC_WORK, AMSC_WAIT: begin
            nxt_bsy = 1'b1;
            nxt_trf = (pul_ff != 8'h0);
         end
         AMSC_ERR: begin
            nxt_trf = 1'b1;
            nxt_bsy = (ms_ff < MSW'(ERR_PER_MS / 2));
         end
         default: nxt_trf = 1'b0;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pul_ff <= 8'h0;
         trf_ff <= 1'b0;
         bsy_ff <= 1'b0;
      end
      else begin
         pul_ff <= nxt_pul;
         trf_ff <= nxt_trf;
         bsy_ff <= nxt_bsy;
      end
   end

   // axi4-lite slave; write address and data may arrive in either order
   logic awr_ff, nxt_awr, wr_ff, nxt_wr, bv_ff, nxt_bv, ar_ff, nxt_ar, rv_ff, nxt_rv;
   logic awg_ff, nxt_awg, wg_ff, nxt_wg;
   logic [3:0] wa_ff, nxt_wa, ws_ff, nxt_ws;
   logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
   logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
   logic [1:0] dir_ff, nxt_dir;
   logic [15:0] dout_ff, nxt_dout, oe_ff, nxt_oe;
   always_comb begin
      nxt_awg = awg_ff || (s_axi_awvalid && awr_ff);
      nxt_wg = wg_ff || (s_axi_wvalid && wr_ff);
      nxt_wa = (s_axi_awvalid && awr_ff) ? s_axi_awaddr : wa_ff;
      nxt_wd = (s_axi_wvalid && wr_ff) ? s_axi_wdata : wd_ff;
      nxt_ws = (s_axi_wvalid && wr_ff) ? s_axi_wstrb : ws_ff;
      nxt_bv = bv_ff && !s_axi_bready;
      nxt_br = br_ff;
      nxt_dir = dir_ff;
      nxt_dout = dout_ff;
      if (awg_ff && wg_ff && !bv_ff) begin
         nxt_awg = 1'b0;
         nxt_wg = 1'b0;
         nxt_bv = 1'b1;
         nxt_br = 2'h0;
         case (wa_ff)
            AMSC_REG_CTRL: if (ws_ff[0]) nxt_dir = wd_ff[1:0];
            AMSC_REG_DOUT: begin
               if (ws_ff[0]) nxt_dout[7:0] = wd_ff[7:0];
               if (ws_ff[1]) nxt_dout[15:8] = wd_ff[15:8];
            end
            AMSC_REG_DIN, AMSC_REG_STAT: nxt_br = 2'h0;
            default: nxt_br = 2'h2;
         endcase
      end
      nxt_awr = !nxt_awg && !nxt_bv;
      nxt_wr = !nxt_wg && !nxt_bv;
      // block direction applies to all eight lines at once
      nxt_oe = {{8{dir_ff[AMSC_CTRL_DIR_HI]}}, {8{dir_ff[AMSC_CTRL_DIR_LO]}}};
      nxt_rv = rv_ff && !s_axi_rready;
      nxt_rd = rd_ff;
      nxt_rr = rr_ff;
      if (s_axi_arvalid && ar_ff) begin
         nxt_rv = 1'b1;
         nxt_rr = 2'h0;
         nxt_rd = 32'h0;
         case (s_axi_araddr)
            AMSC_REG_CTRL: nxt_rd[1:0] = dir_ff;
            AMSC_REG_DOUT: nxt_rd[15:0] = dout_ff;
            AMSC_REG_DIN: nxt_rd[15:0] = dio_in;
            AMSC_REG_STAT: begin
               nxt_rd[5:0] = st_ff;
               nxt_rd[AMSC_STAT_LOCK] = lock_ff;
               nxt_rd[AMSC_STAT_ID +: ID_W] = id_ff;
            end
            default: nxt_rr = 2'h2;
         endcase
      end
      nxt_ar = !nxt_rv;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awr_ff <= 1'b0;
         wr_ff <= 1'b0;
         bv_ff <= 1'b0;
         ar_ff <= 1'b0;
         rv_ff <= 1'b0;
         awg_ff <= 1'b0;
         wg_ff <= 1'b0;
         wa_ff <= 4'h0;
         ws_ff <= 4'h0;
         wd_ff <= 32'h0;
         rd_ff <= 32'h0;
         br_ff <= 2'h0;
         rr_ff <= 2'h0;
         dir_ff <= AMSC_DIR_RST;
         dout_ff <= AMSC_DOUT_RST;
         oe_ff <= 16'h0000;
      end
      else begin
         awr_ff <= nxt_awr;
         wr_ff <= nxt_wr;
         bv_ff <= nxt_bv;
         ar_ff <= nxt_ar;
         rv_ff <= nxt_rv;
         awg_ff <= nxt_awg;
         wg_ff <= nxt_wg;
         wa_ff <= nxt_wa;
         ws_ff <= nxt_ws;
         wd_ff <= nxt_wd;
         rd_ff <= nxt_rd;
         br_ff <= nxt_br;
         rr_ff <= nxt_rr;
         dir_ff <= nxt_dir;
         dout_ff <= nxt_dout;
         oe_ff <= nxt_oe;
      end
   end

   assign s_axi_awready = awr_ff;
   assign s_axi_wready = wr_ff;
   assign s_axi_bvalid = bv_ff;
   assign s_axi_bresp = br_ff;
   assign s_axi_arready = ar_ff;
   assign s_axi_rvalid = rv_ff;
   assign s_axi_rdata = rd_ff;
   assign s_axi_rresp = rr_ff;
   assign cmd_accept = acc_ff;
   assign cmd_drop = drop_ff;
   assign led_traffic = trf_ff;
   assign led_busy = bsy_ff;
   assign dio_out = dout_ff;
   assign dio_oe = oe_ff;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_idle_cmd; st_ff == AMSC_IDLE && cmd_valid; endsequence
   sequence s_locked; st_ff == AMSC_WORK && lock_ff; endsequence
   property p_self_lights; st_ff == AMSC_SELF |=> trf_ff && bsy_ff; endproperty
   a_self_lights: assert property (p_self_lights) else $error("lights not lit in self-test");
   property p_fatal; st_ff == AMSC_SELF && selftest_fatal |=> st_ff == AMSC_ERR; endproperty
   a_fatal: assert property (p_fatal) else $error("fatal fault did not enter error");
   property p_lock; s_idle_cmd |=> s_locked ##0 id_ff == $past(cmd_src) ##0 acc_ff; endproperty
   a_lock: assert property (p_lock) else $error("first command did not lock");
   property p_foreign; lock_ff && cmd_valid && cmd_src != id_ff |=> drop_ff && $stable(id_ff); endproperty
   a_foreign: assert property (p_foreign) else $error("foreign command not dropped");
   property p_wait_lock; s_locked ##1 st_ff == AMSC_WAIT |-> lock_ff && $stable(id_ff); endproperty
   a_wait_lock: assert property (p_wait_lock) else $error("lock lost entering wait");
   property p_resume; st_ff == AMSC_WAIT && cmd_valid && from_lock |=> st_ff == AMSC_WORK ##1 trf_ff; endproperty
   a_resume: assert property (p_resume) else $error("wait did not resume work");
   property p_tmo; st_ff == AMSC_WAIT && !cmd_valid && ms_ff >= MSW'(WAIT_TMO_MS) |=> st_ff == AMSC_IDLE && !lock_ff;
   endproperty
   a_tmo: assert property (p_tmo) else $error("wait timeout not handled");
   property p_dir; ##1 1'b1 |-> oe_ff == {{8{$past(dir_ff[1])}}, {8{$past(dir_ff[0])}}}; endproperty
   a_dir: assert property (p_dir) else $error("block direction mismatch");
   property p_dark; st_ff == AMSC_DARK |=> !trf_ff && !bsy_ff; endproperty
   a_dark: assert property (p_dark) else $error("lights not dark before idle");
   property p_err; st_ff == AMSC_ERR |=> trf_ff; endproperty
   a_err: assert property (p_err) else $error("traffic light not lit in error");
   property p_idle_busy; st_ff == AMSC_IDLE |=> !bsy_ff; endproperty
   a_idle_busy: assert property (p_idle_busy) else $error("busy lit in idle");
   property p_restart; acc |=> ms_ff == '0; endproperty
   a_restart: assert property (p_restart) else $error("timer not restarted");
endmodule : amsc_top
